/* File: rtl/floppy_cfg_params.svh */
// Index, field and reset constants of the floppy logical device configuration bank.
// Assumes an 8-bit index/data configuration port in front of it.
`ifndef FLOPPY_CFG_PARAMS_SVH
`define FLOPPY_CFG_PARAMS_SVH

`define IDX_MODE 8'hF0
`define IDX_OPTION 8'hF1
`define IDX_DRV_TYPE 8'hF2
`define IDX_RSVD_A 8'hF3
`define IDX_DRV0 8'hF4
`define IDX_RSVD_B 8'hF5
`define IDX_TEST 8'hF8

`define RST_MODE 8'h0E
`define RST_OPTION 8'h00
`define RST_DRV_TYPE 8'hFF
`define RST_DRV0 8'h00
`define RST_TEST 8'h24

`define MODE_ENH_BIT 0
`define MODE_DMA_BIT 1
`define MODE_IF_LSB 2
`define MODE_SWAP_BIT 4
`define MODE_PUSHPULL_BIT 6
`define MODE_TRISTATE_BIT 7
`define OPT_FWP_BIT 0
`define OPT_DENS_LSB 2
`define DRV0_DT_LSB 0
`define DRV0_DRT_LSB 3
`define DRV0_PTS_BIT 6

`define MASK_MODE 8'hDF
`define MASK_OPTION 8'h0D
`define MASK_DRV0 8'h5B

`endif

/* File: rtl/floppy_cfg_pkg.sv */
// Types shared by the floppy logical device configuration bank and its users.
// Assumes nothing beyond a SystemVerilog compiler.
package floppy_cfg_pkg;
   typedef enum logic [1:0] {
      IF_ALT_SECOND = 2'b00,
      IF_ALT_FIRST = 2'b01,
      IF_RESERVED = 2'b10,
      IF_AT = 2'b11
   } iface_mode_t;
   typedef enum logic [1:0] {
      DENS_NORMAL = 2'b00,
      DENS_NORMAL_USER = 2'b01,
      DENS_FORCE_ONE = 2'b10,
      DENS_FORCE_ZERO = 2'b11
   } density_sel_t;
endpackage

/* File: rtl/floppy_logical_device_config.sv */
// Configuration register bank of the floppy logical device, plus the drive pin shaping it controls.
// Assumes the configuration port decodes the index/data pair and the logical device selection,
// and that the controller core runs on mclk; drive pins come from outside and are synchronised.
// The pin value and enable pairs are meant for pad cells that drive only while the enable is high.
`include "floppy_cfg_params.svh"

// Overview of operation
// - Registers reset only by power-on or host bus reset; soft reset leaves them alone.
// - Mode bit 0 picks normal (0, default) or enhanced second controller mode.
// - Mode bit 1 picks burst DMA (0) or non-burst DMA (1, default).
// - Mode bits 3:2 pick interface mode; 11 AT default, 10 reserved, 01, 00 alternates.
// - Mode bit 4 swaps drive-select and motor-on outputs of drives 0 and 1.
// - Mode bit 6 chooses open drain (0, default) or push-pull controller outputs.
// - Mode bit 7 set places all controller outputs in high impedance.
// - Forced write protect with a drive selected forces write protect active to core.
// - Option bits 3:2 drive density: 00/01 normal, 10 forces one, 11 forces zero.
// - Drive type register holds drive A type in 1:0, other fields storage, reset 0xFF.
// - Indices 0xF3 and 0xF5 are read-only and always read zero.
// - Drive 0 register stores type in 1:0, rate table in 4:3; bits 2,5,7 read zero.
// - Drive 0 bit 6 set disables write precompensation.
module floppy_logical_device_config
   import floppy_cfg_pkg::*;
#(
   parameter int NUM_DRIVES = 2
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic host_bus_reset_n,
   input wire logic soft_reset,
   input wire logic cfg_select,
   input wire logic [7:0] cfg_index,
   input wire logic cfg_wr,
   input wire logic [7:0] cfg_wdata,
   input wire logic cfg_rd,
   output logic [7:0] cfg_rdata,
   output logic cfg_rvalid,
   input wire logic [1:0] core_drive_select_n,
   input wire logic [1:0] core_motor_on_n,
   input wire logic core_density,
   input wire logic write_protect_n,
   output logic [1:0] drive_select_n_o,
   output logic [1:0] drive_select_n_oe,
   output logic [1:0] motor_on_n_o,
   output logic [1:0] motor_on_n_oe,
   output logic density_o,
   output logic density_oe,
   output logic core_write_protect_n,
   output logic status_reg_a_wp,
   output logic enhanced_mode,
   output logic dma_non_burst,
   output iface_mode_t iface_mode,
   output logic drive_swap,
   output logic outputs_push_pull,
   output logic outputs_tristate,
   output logic [1:0] drive_type_sel,
   output logic [1:0] rate_table_sel,
   output logic precomp_disable,
   output logic [7:0] drive_type_store
);

   // Elaboration checks. The pin logic is written for exactly two drives, and every
   // read-as-zero bit must be cleared by its write mask and by its reset value.
   if (NUM_DRIVES != 2) begin : g_bad_drive_count
      $error("NUM_DRIVES must be 2");
   end
   if ((`MASK_MODE & 8'h20) != 8'h00) begin : g_bad_mode_mask
      $error("Mode mask keeps the reserved bit");
   end
   if ((`MASK_OPTION & 8'hF2) != 8'h00) begin : g_bad_option_mask
      $error("Option mask keeps reserved bits");
   end
   if ((`MASK_DRV0 & 8'hA4) != 8'h00) begin : g_bad_drv0_mask
      $error("Drive 0 mask keeps read-as-zero bits");
   end
   if ((`RST_MODE & ~`MASK_MODE) != 8'h00) begin : g_bad_mode_reset
      $error("Mode reset value sets a masked bit");
   end
   if ((`RST_OPTION & ~`MASK_OPTION) != 8'h00) begin : g_bad_option_reset
      $error("Option reset value sets a masked bit");
   end
   if ((`RST_DRV0 & ~`MASK_DRV0) != 8'h00) begin : g_bad_drv0_reset
      $error("Drive 0 reset value sets a masked bit");
   end
   if (`MODE_TRISTATE_BIT > 7 || `DRV0_PTS_BIT > 7) begin : g_bad_field_pos
      $error("Field position lies outside the 8-bit register");
   end

   // Host bus reset arrives from another domain, so it is synchronised first.
   logic bus_rst_meta;
   logic bus_rst_sync;
   logic wp_meta;
   logic wp_sync;
   logic hard_reset;

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         bus_rst_meta <= 1'b0;
         bus_rst_sync <= 1'b0;
      end else begin
         bus_rst_meta <= host_bus_reset_n;
         bus_rst_sync <= bus_rst_meta;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         wp_meta <= 1'b1;
         wp_sync <= 1'b1;
      end else begin
         wp_meta <= write_protect_n;
         wp_sync <= wp_meta;
      end
   end

   // Soft reset is deliberately not part of this term. Its port stays so that the bank can sit
   // beside logical devices that do use it; here it is read by nothing on purpose, since a soft
   // reset must never disturb the stored configuration.
   assign hard_reset = !rst_b || !bus_rst_sync;

   logic [7:0] mode_reg;
   logic [7:0] option_reg;
   logic [7:0] type_reg;
   logic [7:0] drv0_reg;
   logic [7:0] test_reg;
   // One strobe per register keeps the index decode in a single place; writes to the
   // reserved and unmapped indices decode to no strobe at all, so they are dropped.
   logic wr_hit;
   logic wr_mode;
   logic wr_option;
   logic wr_type;
   logic wr_drv0;
   logic wr_test;

   assign wr_hit = cfg_select && cfg_wr;
   assign wr_mode = wr_hit && (cfg_index == `IDX_MODE);
   assign wr_option = wr_hit && (cfg_index == `IDX_OPTION);
   assign wr_type = wr_hit && (cfg_index == `IDX_DRV_TYPE);
   assign wr_drv0 = wr_hit && (cfg_index == `IDX_DRV0);
   assign wr_test = wr_hit && (cfg_index == `IDX_TEST);

   always_ff @(posedge mclk) begin
      if (hard_reset) begin
         mode_reg <= `RST_MODE;
      end else if (wr_mode) begin
         mode_reg <= cfg_wdata & `MASK_MODE;
      end
   end

   always_ff @(posedge mclk) begin
      if (hard_reset) begin
         option_reg <= `RST_OPTION;
      end else if (wr_option) begin
         option_reg <= cfg_wdata & `MASK_OPTION;
      end
   end

   always_ff @(posedge mclk) begin
      if (hard_reset) begin
         type_reg <= `RST_DRV_TYPE;
      end else if (wr_type) begin
         type_reg <= cfg_wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (hard_reset) begin
         drv0_reg <= `RST_DRV0;
      end else if (wr_drv0) begin
         drv0_reg <= cfg_wdata & `MASK_DRV0;
      end
   end

   // Test bits are kept only for read-back; they steer nothing here.
   always_ff @(posedge mclk) begin
      if (hard_reset) begin
         test_reg <= `RST_TEST;
      end else if (wr_test) begin
         test_reg <= cfg_wdata;
      end
   end

   // Read data, one cycle after the strobe; unmapped indices read zero.
   // A read and a write in one cycle return the old value, since the mux sees the stored register.
   logic [7:0] next_rdata;

   always_comb begin
      case (cfg_index)
         `IDX_MODE: next_rdata = mode_reg;
         `IDX_OPTION: next_rdata = option_reg;
         `IDX_DRV_TYPE: next_rdata = type_reg;
         `IDX_DRV0: next_rdata = drv0_reg;
         `IDX_TEST: next_rdata = test_reg;
         `IDX_RSVD_A: next_rdata = 8'h00;
         `IDX_RSVD_B: next_rdata = 8'h00;
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (hard_reset) begin
         cfg_rdata <= 8'h00;
         cfg_rvalid <= 1'b0;
      end else begin
         cfg_rdata <= (cfg_select && cfg_rd) ? next_rdata : 8'h00;
         cfg_rvalid <= cfg_select && cfg_rd;
      end
   end

   // Core-facing settings are registered copies, so they follow a write by one more cycle.
   always_ff @(posedge mclk) begin
      if (hard_reset) begin
         enhanced_mode <= 1'b0;
         dma_non_burst <= 1'b1;
         iface_mode <= IF_AT;
         drive_swap <= 1'b0;
         outputs_push_pull <= 1'b0;
         outputs_tristate <= 1'b0;
      end else begin
         enhanced_mode <= mode_reg[`MODE_ENH_BIT];
         dma_non_burst <= mode_reg[`MODE_DMA_BIT];
         iface_mode <= iface_mode_t'(mode_reg[`MODE_IF_LSB +: 2]);
         drive_swap <= mode_reg[`MODE_SWAP_BIT];
         outputs_push_pull <= mode_reg[`MODE_PUSHPULL_BIT];
         outputs_tristate <= mode_reg[`MODE_TRISTATE_BIT];
      end
   end

   always_ff @(posedge mclk) begin
      if (hard_reset) begin
         drive_type_sel <= 2'h0;
         rate_table_sel <= 2'h0;
         precomp_disable <= 1'b0;
         drive_type_store <= `RST_DRV_TYPE;
      end else begin
         drive_type_sel <= drv0_reg[`DRV0_DT_LSB +: 2];
         rate_table_sel <= drv0_reg[`DRV0_DRT_LSB +: 2];
         precomp_disable <= drv0_reg[`DRV0_PTS_BIT];
         drive_type_store <= type_reg;
      end
   end

   // Write protect to the core, active low; a selected drive is a low select line.
   logic wp_forced;
   logic next_wp_n;

   assign wp_forced = option_reg[`OPT_FWP_BIT] && (core_drive_select_n != 2'b11);
   assign next_wp_n = !(wp_forced || !wp_sync);

   always_ff @(posedge mclk) begin
      if (hard_reset) begin
         core_write_protect_n <= 1'b1;
         status_reg_a_wp <= 1'b0;
      end else begin
         core_write_protect_n <= next_wp_n;
         status_reg_a_wp <= !next_wp_n;
      end
   end

   // Decoded mode and option fields shared by the density and pin logic.
   logic mode_swap;
   logic mode_push_pull;
   logic mode_tristate;
   density_sel_t density_code;

   assign mode_swap = mode_reg[`MODE_SWAP_BIT];
   assign mode_push_pull = mode_reg[`MODE_PUSHPULL_BIT];
   assign mode_tristate = mode_reg[`MODE_TRISTATE_BIT];
   assign density_code = density_sel_t'(option_reg[`OPT_DENS_LSB +: 2]);

   // Density level after the override code.
   logic next_density;

   always_comb begin
      case (density_code)
         DENS_FORCE_ONE: next_density = 1'b1;
         DENS_FORCE_ZERO: next_density = 1'b0;
         default: next_density = core_density;
      endcase
   end

   // Density enable follows the same output style as the drive pins.
   logic next_density_oe;

   always_comb begin
      if (mode_tristate) begin
         next_density_oe = 1'b0;
      end else if (mode_push_pull) begin
         next_density_oe = 1'b1;
      end else begin
         next_density_oe = !next_density;
      end
   end

   // Pin shaping. Open drain drives only the low level; push-pull drives both;
   // tri-state releases every pin whatever the other bits say. The pin values keep
   // following the core while released, so leaving tri-state shows no stale level.
   logic [1:0] sel_swapped;
   logic [1:0] mtr_swapped;
   logic [1:0] next_sel_oe;
   logic [1:0] next_mtr_oe;

   assign sel_swapped = mode_swap ? {core_drive_select_n[0], core_drive_select_n[1]}
                                  : core_drive_select_n;
   assign mtr_swapped = mode_swap ? {core_motor_on_n[0], core_motor_on_n[1]}
                                  : core_motor_on_n;

   genvar g;
   generate
      for (g = 0; g < NUM_DRIVES; g++) begin : g_drive_pin
         assign next_sel_oe[g] = mode_tristate ? 1'b0
                               : (mode_push_pull ? 1'b1 : !sel_swapped[g]);
         assign next_mtr_oe[g] = mode_tristate ? 1'b0
                               : (mode_push_pull ? 1'b1 : !mtr_swapped[g]);
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (hard_reset) begin
         drive_select_n_o <= 2'b11;
         drive_select_n_oe <= 2'b00;
         motor_on_n_o <= 2'b11;
         motor_on_n_oe <= 2'b00;
      end else begin
         drive_select_n_o <= sel_swapped;
         drive_select_n_oe <= next_sel_oe;
         motor_on_n_o <= mtr_swapped;
         motor_on_n_oe <= next_mtr_oe;
      end
   end

   always_ff @(posedge mclk) begin
      if (hard_reset) begin
         density_o <= 1'b1;
         density_oe <= 1'b0;
      end else begin
         density_o <= next_density;
         density_oe <= next_density_oe;
      end
   end

endmodule

/* File: test/floppy_cfg_properties.sv */
// Port-level checks for the floppy configuration bank.
// Assumes a bind to the bank and the single clock mclk.
module floppy_cfg_properties (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic cfg_select,
   input wire logic [7:0] cfg_index,
   input wire logic cfg_wr,
   input wire logic [7:0] cfg_wdata,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_rdata,
   input wire logic cfg_rvalid,
   input wire logic [1:0] core_drive_select_n,
   input wire logic [1:0] drive_select_n_o,
   input wire logic [1:0] drive_select_n_oe,
   input wire logic [1:0] motor_on_n_oe,
   input wire logic density_oe,
   input wire logic core_write_protect_n,
   input wire logic status_reg_a_wp,
   input wire logic drive_swap,
   input wire logic outputs_push_pull,
   input wire logic outputs_tristate
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   sequence s_rd;
      cfg_select && cfg_rd;
   endsequence
   sequence s_mode_wr;
      cfg_select && cfg_wr && cfg_index == 8'hF0;
   endsequence
   a_read_answer: assert property (s_rd |=> cfg_rvalid) else $error("read not answered");
   a_rdata_idle: assert property (!cfg_rvalid |-> cfg_rdata == 8'h00) else $error("idle read data");
   a_reserved_zero: assert property (s_rd ##0 (cfg_index == 8'hF3 || cfg_index == 8'hF5) |=>
      cfg_rdata == 8'h00) else $error("reserved index not zero");
   a_drv0_fixed_zero: assert property (s_rd ##0 cfg_index == 8'hF4 |=> (cfg_rdata & 8'hA4) == 8'h00)
      else $error("fixed zero bits set");
   a_tristate_pins: assert property (outputs_tristate |-> drive_select_n_oe == 2'b00
      && motor_on_n_oe == 2'b00 && !density_oe) else $error("pins driven in tristate");
   a_push_pull_oe: assert property (!outputs_tristate && outputs_push_pull |-> drive_select_n_oe == 2'b11
      && motor_on_n_oe == 2'b11) else $error("push-pull not driving");
   a_open_drain_oe: assert property (!outputs_tristate && !outputs_push_pull |->
      drive_select_n_oe == ~drive_select_n_o) else $error("open drain drives high");
   a_swap_select: assert property (!outputs_tristate && drive_swap |-> drive_select_n_o ==
      {$past(core_drive_select_n[0]), $past(core_drive_select_n[1])}) else $error("selects not swapped");
   a_straight_select: assert property (!outputs_tristate && !drive_swap |->
      drive_select_n_o == $past(core_drive_select_n)) else $error("selects swapped");
   a_wp_status: assert property (status_reg_a_wp == !core_write_protect_n) else $error("status mismatch");
   a_mode_apply: assert property (s_mode_wr |-> ##2 drive_swap == $past(cfg_wdata[4], 2))
      else $error("mode write not applied");
endmodule

/* File: test/drive_model.sv */
// Drive cable model: pull-ups on the select and motor lines, and the write-protect sense line.
// Assumes the bank's pin value and enable pairs are wired straight in.
module drive_model (
   input wire logic [1:0] ds_o,
   input wire logic [1:0] ds_oe,
   input wire logic [1:0] mtr_o,
   input wire logic [1:0] mtr_oe,
   input wire logic wp_level,
   output logic [1:0] ds_pin,
   output logic [1:0] mtr_pin,
   output logic write_protect_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // A released line floats to the pull-up, so a stale driven level can never pass for a match.
   assign ds_pin = ds_o | ~ds_oe;
   assign mtr_pin = mtr_o | ~mtr_oe;
   assign write_protect_n = wp_level;
endmodule

/* File: test/tb.sv */
// Self-checking bench for the floppy configuration bank.
// Assumes the bank, its package and the drive model are compiled first.
module tb
   import floppy_cfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [7:0] i; logic [7:0] d; logic [7:0] e;} row_t;
   row_t rows [9] = '{'{8'hF0, 8'hFF, 8'hDF}, '{8'hF1, 8'hFF, 8'h0D}, '{8'hF2, 8'h5A, 8'h5A},
      '{8'hF3, 8'hFF, 8'h00}, '{8'hF4, 8'hFF, 8'h5B}, '{8'hF5, 8'hFF, 8'h00}, '{8'hE0, 8'hFF, 8'h00},
      '{8'hF0, 8'h0E, 8'h0E}, '{8'hF1, 8'h00, 8'h00}};
   logic [7:0] def_idx [5] = '{8'hF0, 8'hF1, 8'hF2, 8'hF4, 8'hF8};
   logic [7:0] def_val [5] = '{8'h0E, 8'h00, 8'hFF, 8'h00, 8'h24};
   logic mclk = 0, rst_b = 0, hbr_n = 1, soft_reset = 0, sel = 0, wr = 0, rd = 0, core_dens = 0, wp_level = 1;
   logic [7:0] idx = 8'h00, wd = 8'h00, rdata, v;
   logic [1:0] core_ds = 2'b11, core_mtr = 2'b11, ds_o, ds_oe, mtr_o, mtr_oe, ds_pin, mtr_pin, dts, rts;
   logic rvalid, dens_o, dens_oe, cwp_n, sra_wp, enh, dma_nb, swap, pp, tri_s, pdis, wp_n;
   logic [7:0] dstore;
   iface_mode_t ifm;
   int miscompares = 0, check_count = 0, cycles = 0;
   floppy_logical_device_config dut_u (.mclk(mclk), .rst_b(rst_b), .host_bus_reset_n(hbr_n),
      .soft_reset(soft_reset), .cfg_select(sel), .cfg_index(idx), .cfg_wr(wr), .cfg_wdata(wd), .cfg_rd(rd),
      .cfg_rdata(rdata), .cfg_rvalid(rvalid), .core_drive_select_n(core_ds), .core_motor_on_n(core_mtr),
      .core_density(core_dens), .write_protect_n(wp_n), .drive_select_n_o(ds_o), .drive_select_n_oe(ds_oe),
      .motor_on_n_o(mtr_o), .motor_on_n_oe(mtr_oe), .density_o(dens_o), .density_oe(dens_oe),
      .core_write_protect_n(cwp_n), .status_reg_a_wp(sra_wp), .enhanced_mode(enh), .dma_non_burst(dma_nb),
      .iface_mode(ifm), .drive_swap(swap), .outputs_push_pull(pp), .outputs_tristate(tri_s),
      .drive_type_sel(dts), .rate_table_sel(rts), .precomp_disable(pdis), .drive_type_store(dstore));
   drive_model model_u (.ds_o(ds_o), .ds_oe(ds_oe), .mtr_o(mtr_o), .mtr_oe(mtr_oe), .wp_level(wp_level),
      .ds_pin(ds_pin), .mtr_pin(mtr_pin), .write_protect_n(wp_n));
   initial begin
      forever #5 mclk = ~mclk;
   end
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] i, input logic [7:0] d);
      @(posedge mclk);
      idx <= i;
      wd <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] i, output logic [7:0] q);
      @(posedge mclk);
      idx <= i;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 q = rdata;
   endtask
   task automatic settle;
      repeat (2) @(posedge mclk);
      #1;
   endtask
   task automatic check_defaults;
      // The test register is only read here; its bits steer nothing, so only its reset value is checked.
      for (int k = 0; k < 5; k++) begin
         rd_reg(def_idx[k], v);
         chk(v, def_val[k]);
      end
      chk(dma_nb, 1'b1);
      chk(ifm, IF_AT);
      chk(dstore, 8'hFF);
   endtask
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         end_sim;
      end
   end
   initial begin
      repeat (16) @(posedge mclk);
      rst_b <= 1'b1;
      sel <= 1'b1;
      repeat (3) @(posedge mclk);
      check_defaults;
      $display("defaults done");
      foreach (rows[k]) begin
         wr_reg(rows[k].i, rows[k].d);
         rd_reg(rows[k].i, v);
         chk(v, rows[k].e);
      end
      $display("register table done");
      for (int k = 0; k < 4; k++) begin
         wr_reg(8'hF0, {4'h0, k[1:0], k[1:0]});
         settle;
         chk(ifm, k[1:0]);
         chk(enh, k[0]);
         chk(dma_nb, k[1]);
      end
      @(posedge mclk);
      core_ds <= 2'b10;
      core_mtr <= 2'b10;
      wr_reg(8'hF0, 8'h1E);
      settle;
      chk(ds_pin, 2'b01);
      chk(mtr_pin, 2'b01);
      chk(swap, 1'b1);
      chk(pp, 1'b0);
      wr_reg(8'hF0, 8'h4E);
      settle;
      chk(ds_oe, 2'b11);
      chk(ds_pin, 2'b10);
      chk(mtr_pin, 2'b10);
      chk(pp, 1'b1);
      wr_reg(8'hF0, 8'hCE);
      settle;
      chk(tri_s, 1'b1);
      chk(ds_oe, 2'b00);
      chk(mtr_oe, 2'b00);
      chk(dens_oe, 1'b0);
      chk(ds_pin, 2'b11);
      wr_reg(8'hF0, 8'h0E);
      $display("mode and pins done");
      wr_reg(8'hF1, 8'h01);
      settle;
      chk(cwp_n, 1'b0);
      chk(sra_wp, 1'b1);
      core_ds <= 2'b11;
      settle;
      chk(cwp_n, 1'b1);
      wp_level <= 1'b0;
      repeat (4) @(posedge mclk);
      #1 chk(cwp_n, 1'b0);
      wp_level <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         core_dens <= k[0];
         wr_reg(8'hF1, {4'h0, k[1:0], 2'b00});
         settle;
         chk(dens_o, k[1] ? !k[0] : k[0]);
         chk(dens_oe, !(k[1] ? !k[0] : k[0]));
      end
      wr_reg(8'hF4, 8'h59);
      settle;
      chk(dts, 2'b01);
      chk(rts, 2'b11);
      chk(pdis, 1'b1);
      $display("option and drive done");
      soft_reset <= 1'b1;
      repeat (4) @(posedge mclk);
      soft_reset <= 1'b0;
      rd_reg(8'hF4, v);
      chk(v, 8'h59);
      hbr_n <= 1'b0;
      repeat (6) @(posedge mclk);
      hbr_n <= 1'b1;
      repeat (6) @(posedge mclk);
      check_defaults;
      $display("resets done");
      end_sim;
   end
endmodule
bind floppy_logical_device_config floppy_cfg_properties chk_u (.mclk, .rst_b, .cfg_select, .cfg_index, .cfg_wr,
   .cfg_wdata, .cfg_rd, .cfg_rdata, .cfg_rvalid, .core_drive_select_n, .drive_select_n_o, .drive_select_n_oe,
   .motor_on_n_oe, .density_oe, .core_write_protect_n, .status_reg_a_wp, .drive_swap, .outputs_push_pull,
   .outputs_tristate);
